// ==== inc/laser_prot_pkg.sv ====
/*
 * Constants for the gate protection and simmer block: timing, limits,
 * register offsets, field positions and reset values.
 * Assumes a single 40 MHz clock; all counts derive from it here.
 */
package laser_prot_pkg;
    // ----------------------------------------------------------------
    // Clock and counter sizing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 40;
    localparam int CLK_NS  = 25;
    localparam int CW      = 20;                // Counter width

    // ----------------------------------------------------------------
    // Pulse limits
    // ----------------------------------------------------------------
    localparam int MAX_PULSE_US  = 1000;
    localparam int MAX_PULSE_CYC = MAX_PULSE_US * CLK_MHZ;
    localparam int DUTY_SCALE    = 100;
    localparam int DUTY_MAX_PCT  = 40;

    // ----------------------------------------------------------------
    // Simmer timing
    // ----------------------------------------------------------------
    localparam int SIM_PERIOD_US  = 1000;
    localparam int SIM_PERIOD_CYC = SIM_PERIOD_US * CLK_MHZ;
    localparam int SIM_TMO_US     = 10000;
    localparam int SIM_TMO_CYC    = SIM_TMO_US * CLK_MHZ;
    localparam int SIM_PW_NS      = 5000;
    localparam int SIM_PW_CYC     = (SIM_PW_NS + CLK_NS - 1) / CLK_NS;
    localparam int SIM_LIM_NS     = 1000;
    localparam int SIM_LIM_CYC    = (SIM_LIM_NS + CLK_NS - 1) / CLK_NS;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0]  CTRL_OFS   = 8'h00;
    localparam logic [7:0]  RATIO_OFS  = 8'h04;
    localparam logic [7:0]  STAT_OFS   = 8'h08;
    localparam int          CTRL_SIM_EN_BIT = 0;
    localparam logic        CTRL_SIM_EN_RST = 1'b1;
    localparam logic [7:0]  RATIO_RST  = 8'h32;
    localparam logic [1:0]  RESP_OKAY  = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;

    // Status bit positions
    localparam int ST_ENABLED = 0;
    localparam int ST_FAULT   = 1;
    localparam int ST_OVER    = 2;
    localparam int ST_REFL    = 3;
    localparam int ST_LIMITED = 4;
    localparam int ST_ILK     = 5;
    localparam int ST_GATE    = 6;
    localparam int ST_LASER   = 7;

    // Synchronised input lanes
    localparam int NSYNC  = 4;
    localparam int IN_GATE = 0;
    localparam int IN_PERMIT = 1;
    localparam int IN_ILK = 2;
    localparam int IN_BRK = 3;
endpackage

// ==== inc/sync_if.sv ====
/*
 * Carrier for asynchronous pin levels and their synchronised copies.
 * Assumes the raw side is driven from pins outside the clock domain.
 */
`timescale 1ns/1ps
interface sync_if;
    logic [laser_prot_pkg::NSYNC-1:0] raw;      // Pin levels
    logic [laser_prot_pkg::NSYNC-1:0] synced;   // Clock-domain copies
    modport sync_side (input raw, output synced);
    modport user_side (output raw, input synced);
endinterface

// ==== design/pin_sync.sv ====
/*
 * Two-flop synchroniser for a group of pin levels.
 * Assumes the levels change slowly against the 25 ns clock.
 */
`timescale 1ns/1ps
module pin_sync (
    input  wire logic        aclk,    // System clock
    input  wire logic        aresetn, // Sync reset, active low
    sync_if.sync_side        pins     // Raw in, synced out
);
    typedef struct packed {
        logic [laser_prot_pkg::NSYNC-1:0] meta;
        logic [laser_prot_pkg::NSYNC-1:0] stable;
    } sync_state_t;

    sync_state_t s_r;
    sync_state_t s_nxt;

    // Meta stage feeds only the stable stage
    always_comb begin
        s_nxt.meta   = pins.raw;
        s_nxt.stable = s_r.meta;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pins.synced = s_r.stable;
endmodule

// ==== design/laser_gate_prot.sv ====
/*
 * Gate protection, fault latch, reflection guard and simmer generator
 * with an AXI4-Lite register slave.
 * Assumes one 40 MHz clock; pin inputs are asynchronous, the RF level
 * words and the fault event come from logic on the same clock.
 */
// What this block does
// R1 - Laser operation enabled once the permit line closes after power-up.
// R2 - Latched fault clears only on permit open then close.
// R3 - Output only during gate high; width is high time, period rise to rise.
// R4 - Gate pulses longer than maximum width truncated to exactly that width.
// R5 - Duty cycle is width over period times 100, compared to limit.
// R6 - Overlimit flag high when duty or width exceeds its limit.
// R7 - Duty limit is 40 percent; 50 percent is a violation.
// R8 - Both flags high exactly while protection limits the output.
// R9 - Reflection flag when reflected over forward ratio exceeds preset limit.
// R10 - Reflection flag high for the suppressed part of each gate pulse.
// R11 - Host ignores reflection flag at start-up, samples after about 100 ms; the host model never reads it and the bench checks it with no start-up wait.
// R12 - Simmer pulses start at power-up when the interlock is closed.
// R13 - Open interlock disables both gating and simmer at once.
// R14 - Simmer without breakdown beyond timeout gets shortened pulses.
// R15 - Simmer stops immediately while the gate is high.
// R16 - Simmer resumes only after gate low a full simmer period.
// R17 - Maximum pulse width is 1 ms alongside the 40 percent limit.
// R18 - Overlimit flag only on the violating part, low while gate low.
// R19 - Latched error output high while a system fault is present.
// R20 - All timing measured by internal counters against fixed limits.
// R21 - Gate, permit and interlock pins synchronised before use.
`timescale 1ns/1ps
module laser_gate_prot #(
    parameter logic [19:0] MAX_PULSE_CYC  = 20'(laser_prot_pkg::MAX_PULSE_CYC),
    parameter logic [19:0] SIM_PERIOD_CYC = 20'(laser_prot_pkg::SIM_PERIOD_CYC),
    parameter logic [19:0] SIM_TMO_CYC    = 20'(laser_prot_pkg::SIM_TMO_CYC)
) (
    input  wire logic        aclk,                  // System clock
    input  wire logic        aresetn,               // Sync reset, active low
    input  wire logic        beam_gate_in,          // Gate pin, async
    input  wire logic        run_permit_clear_in,   // 1 = closed to return
    input  wire logic        interlock_in,          // 1 = interlock closed
    input  wire logic        breakdown_in,          // Gas breakdown sense
    input  wire logic        fault_event_in,        // System fault pulse
    input  wire logic [11:0] fwd_level_in,          // Forward RF level
    input  wire logic [11:0] refl_level_in,         // Reflected RF level
    output logic             laser_out,             // Power stage on
    output logic             simmer_out,            // Simmer pulse
    output logic             pulse_overlimit_flag,  // Width/duty limiting
    output logic             reflection_guard_flag, // Reflection limiting
    output logic             latched_error_out,     // Fault present
    input  wire logic [7:0]  s_axi_awaddr,          // Write address
    input  wire logic        s_axi_awvalid,         // Write address valid
    output logic             s_axi_awready,         // Write address ready
    input  wire logic [31:0] s_axi_wdata,           // Write data
    input  wire logic [3:0]  s_axi_wstrb,           // Byte enables
    input  wire logic        s_axi_wvalid,          // Write data valid
    output logic             s_axi_wready,          // Write data ready
    output logic [1:0]       s_axi_bresp,           // Write response
    output logic             s_axi_bvalid,          // Write response valid
    input  wire logic        s_axi_bready,          // Write response ready
    input  wire logic [7:0]  s_axi_araddr,          // Read address
    input  wire logic        s_axi_arvalid,         // Read address valid
    output logic             s_axi_arready,         // Read address ready
    output logic [31:0]      s_axi_rdata,           // Read data
    output logic [1:0]       s_axi_rresp,           // Read response
    output logic             s_axi_rvalid,          // Read data valid
    input  wire logic        s_axi_rready           // Read data ready
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        aw_got;
        logic [7:0]  aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic        w_strb0;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        sim_en;
        logic [7:0]  ratio;
        logic        enabled;
        logic        fault;
        logic        open_seen;
        logic        gate_d;
        logic [19:0] wid;
        logic [19:0] per;
        logic [19:0] prev_per;
        logic [19:0] sim_cnt;
        logic [19:0] sim_pw;
        logic [19:0] bd_cnt;
        logic        limited;
        logic        laser;
        logic        simmer;
        logic        over;
        logic        refl;
    } prot_state_t;

    prot_state_t s_r;
    prot_state_t s_nxt;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    sync_if pins ();

    // Breakdown sense is a pin too, so it shares the synchroniser
    assign pins.raw = {breakdown_in, interlock_in, run_permit_clear_in, beam_gate_in};

    pin_sync u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pins    (pins)
    );

    logic gate;
    logic permit;
    logic ilk;
    logic brk;
    assign gate   = pins.synced[laser_prot_pkg::IN_GATE];   // R21
    assign permit = pins.synced[laser_prot_pkg::IN_PERMIT]; // R21
    assign ilk    = pins.synced[laser_prot_pkg::IN_ILK];    // R21
    assign brk    = pins.synced[laser_prot_pkg::IN_BRK];

    // ----------------------------------------------------------------
    // Limit comparisons
    // ----------------------------------------------------------------
    logic [27:0] duty_lhs;
    logic [27:0] duty_rhs;
    logic [19:0] refl_lhs;
    logic [19:0] refl_rhs;
    logic        duty_bad;
    logic        width_bad;
    logic        refl_over;
    logic        over_now;
    logic        refl_now;

    // Width against the last whole period; a first pulse has no period
    assign duty_lhs  = 28'(s_r.wid) * 28'(laser_prot_pkg::DUTY_SCALE);         // R5
    assign duty_rhs  = 28'(s_r.prev_per) * 28'(laser_prot_pkg::DUTY_MAX_PCT); // R7
    assign duty_bad  = duty_lhs > duty_rhs;                                    // R5
    assign width_bad = s_r.wid >= MAX_PULSE_CYC;                               // R4 R17
    assign refl_lhs  = 20'(refl_level_in) * 20'(laser_prot_pkg::DUTY_SCALE);
    assign refl_rhs  = 20'(fwd_level_in) * 20'(s_r.ratio);
    assign refl_over = refl_lhs > refl_rhs;                                    // R9
    // Flags only while gate is high, so they mark the inhibited part
    assign over_now  = gate && (duty_bad || width_bad);                        // R6 R18
    assign refl_now  = gate && refl_over && !over_now;                         // R10

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    logic        aw_hs;
    logic        w_hs;
    logic        ar_hs;
    logic [7:0]  wa;
    logic [31:0] wd;
    logic        ws0;
    logic        sim_ok;

    assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
    assign s_axi_wready  = !s_r.w_got && !s_r.bvalid;
    assign s_axi_arready = !s_r.rvalid;
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs  = s_axi_wvalid && s_axi_wready;
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign wa    = s_r.aw_got ? s_r.aw_addr : s_axi_awaddr;
    assign wd    = s_r.w_got ? s_r.w_data : s_axi_wdata;
    assign ws0   = s_r.w_got ? s_r.w_strb0 : s_axi_wstrb[0];
    assign sim_ok = ilk && !gate && s_r.sim_en;                                // R13 R15

    always_comb begin
        s_nxt = s_r;
        // Bus write: address and data in either order, answer after both
        if (aw_hs) begin
            s_nxt.aw_got  = 1'b1;
            s_nxt.aw_addr = s_axi_awaddr;
        end
        if (w_hs) begin
            s_nxt.w_got   = 1'b1;
            s_nxt.w_data  = s_axi_wdata;
            s_nxt.w_strb0 = s_axi_wstrb[0];
        end
        if ((s_r.aw_got || aw_hs) && (s_r.w_got || w_hs)) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got  = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = laser_prot_pkg::RESP_OKAY;
            unique case (wa)
                laser_prot_pkg::CTRL_OFS: begin
                    if (ws0) begin
                        s_nxt.sim_en = wd[laser_prot_pkg::CTRL_SIM_EN_BIT];
                    end
                end
                laser_prot_pkg::RATIO_OFS: begin
                    if (ws0) begin
                        s_nxt.ratio = wd[7:0];
                    end
                end
                laser_prot_pkg::STAT_OFS: ;
                default: s_nxt.bresp = laser_prot_pkg::RESP_SLVERR;
            endcase
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        // Bus read: data registered on the same edge that takes the address
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (ar_hs) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = laser_prot_pkg::RESP_OKAY;
            s_nxt.rdata  = '0;
            unique case (s_axi_araddr)
                laser_prot_pkg::CTRL_OFS: s_nxt.rdata[0] = s_r.sim_en;
                laser_prot_pkg::RATIO_OFS: s_nxt.rdata[7:0] = s_r.ratio;
                laser_prot_pkg::STAT_OFS: begin
                    s_nxt.rdata[laser_prot_pkg::ST_ENABLED] = s_r.enabled;
                    s_nxt.rdata[laser_prot_pkg::ST_FAULT]   = s_r.fault;
                    s_nxt.rdata[laser_prot_pkg::ST_OVER]    = s_r.over;
                    s_nxt.rdata[laser_prot_pkg::ST_REFL]    = s_r.refl;
                    s_nxt.rdata[laser_prot_pkg::ST_LIMITED] = s_r.limited;
                    s_nxt.rdata[laser_prot_pkg::ST_ILK]     = ilk;
                    s_nxt.rdata[laser_prot_pkg::ST_GATE]    = gate;
                    s_nxt.rdata[laser_prot_pkg::ST_LASER]   = s_r.laser;
                end
                default: s_nxt.rresp = laser_prot_pkg::RESP_SLVERR;
            endcase
        end

        // Enable and fault latch; a new fault beats a same-cycle clear
        if (permit) begin
            s_nxt.enabled = 1'b1;                                              // R1
        end
        if (!permit && s_r.fault) begin
            s_nxt.open_seen = 1'b1;                                            // R2
        end
        if (permit && s_r.open_seen) begin
            s_nxt.fault     = 1'b0;                                            // R2
            s_nxt.open_seen = 1'b0;
        end
        if (fault_event_in) begin
            s_nxt.fault     = 1'b1;                                            // R19
            s_nxt.open_seen = 1'b0;
        end

        // Pulse width and rise-to-rise period, saturating
        s_nxt.gate_d = gate;
        s_nxt.wid = gate ? ((&s_r.wid) ? s_r.wid : s_r.wid + 20'd1) : '0;      // R3 R20
        if (gate && !s_r.gate_d) begin
            s_nxt.prev_per = s_r.per;                                          // R3
            s_nxt.per      = 20'd1;
        end else if (!(&s_r.per)) begin
            s_nxt.per = s_r.per + 20'd1;                                       // R20
        end

        // Output stage and flags, one register each
        s_nxt.laser = gate && ilk && s_r.enabled && !s_r.fault
                      && !over_now && !refl_now;                               // R3 R4 R13
        s_nxt.over  = over_now;                                                // R8
        s_nxt.refl  = refl_now;                                                // R8 R10

        // Simmer: any gate or open interlock restarts the full wait
        if (!sim_ok) begin
            s_nxt.sim_cnt = '0;                                                // R16
            s_nxt.sim_pw  = '0;                                                // R15
        end else begin
            if (s_r.sim_cnt == SIM_PERIOD_CYC - 20'd1) begin
                s_nxt.sim_cnt = '0;                                            // R12 R16
                s_nxt.sim_pw  = s_r.limited ? 20'(laser_prot_pkg::SIM_LIM_CYC)
                                            : 20'(laser_prot_pkg::SIM_PW_CYC); // R14
            end else begin
                s_nxt.sim_cnt = s_r.sim_cnt + 20'd1;
                if (s_r.sim_pw != '0) begin
                    s_nxt.sim_pw = s_r.sim_pw - 20'd1;
                end
            end
        end
        s_nxt.simmer = sim_ok && (s_nxt.sim_pw != '0);

        // No breakdown within the timeout shortens later simmer pulses
        if (brk || gate || !ilk) begin
            s_nxt.bd_cnt = '0;
            if (brk) begin
                s_nxt.limited = 1'b0;
            end
        end else if (s_r.sim_pw != '0) begin
            if (s_r.bd_cnt == SIM_TMO_CYC - 20'd1) begin
                s_nxt.limited = 1'b1;                                          // R14
            end else begin
                s_nxt.bd_cnt = s_r.bd_cnt + 20'd1;
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r          <= '0;
            s_r.sim_en   <= laser_prot_pkg::CTRL_SIM_EN_RST;
            s_r.ratio    <= laser_prot_pkg::RATIO_RST;
            s_r.prev_per <= '1;
            s_r.per      <= '1;                 // First rise sees no whole period
        end else begin
            s_r <= s_nxt;
        end
    end

    assign laser_out             = s_r.laser;
    assign simmer_out            = s_r.simmer;
    assign pulse_overlimit_flag  = s_r.over;
    assign reflection_guard_flag = s_r.refl;
    assign latched_error_out     = s_r.fault;
    assign s_axi_bvalid          = s_r.bvalid;
    assign s_axi_bresp           = s_r.bresp;
    assign s_axi_rvalid          = s_r.rvalid;
    assign s_axi_rdata           = s_r.rdata;
    assign s_axi_rresp           = s_r.rresp;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_width_trunc: assert property (gate && s_r.wid >= MAX_PULSE_CYC |=> !laser_out) // R4
        else $error("laser on past maximum width");
    a_over_idle: assert property (!gate |=> !pulse_overlimit_flag) // R18
        else $error("overlimit flag with gate low");
    a_over_width: assert property (gate && width_bad |=> pulse_overlimit_flag) // R6
        else $error("width violation not flagged");
    a_duty_limit: assert property (gate && duty_bad |=> !laser_out && pulse_overlimit_flag) // R7
        else $error("duty violation not limited");
    a_refl_supp: assert property (reflection_guard_flag |-> !laser_out) // R10
        else $error("reflection flag while laser on");
    a_refl_cause: assert property (gate && refl_over && !over_now |=> reflection_guard_flag) // R9
        else $error("reflection excess not flagged");
    a_ilk_kill: assert property (!ilk |=> !laser_out && !simmer_out) // R13
        else $error("output while interlock open");
    a_gate_simmer: assert property (gate |=> !simmer_out && s_r.sim_cnt == '0) // R15
        else $error("simmer during gate");
    a_fault_clear: assert property ($fell(latched_error_out) |-> $past(permit)
                                    && $past(s_r.open_seen)) // R2
        else $error("fault cleared without permit cycle");
    a_fault_hold: assert property (fault_event_in |=> latched_error_out) // R19
        else $error("fault not latched");
    a_enable_gate: assert property (!s_r.enabled |=> !laser_out) // R1
        else $error("laser on before enable");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
endmodule

// ==== verif/laser_host_model.sv ====
/* Host controller model driving the gate and permit pins.
   Assumes one clock; each task aligns itself to a rising edge. */
`timescale 1ns/1ps
module laser_host_model (
    input  wire logic aclk,   // System clock
    output logic      gate,   // Gate pin level
    output logic      permit  // Permit pin, 1 = closed
);
    // Both lines idle low until commanded
    initial begin
        gate = 1'h0;
        permit = 1'h0;
    end
    // One gate pulse, hi cycles high then lo cycles low
    task automatic pulse(input int hi, input int lo);
        @(posedge aclk);
        gate <= 1'h1;
        repeat (hi) @(posedge aclk);
        gate <= 1'h0;
        repeat (lo) @(posedge aclk);
    endtask
    // Held long enough to pass the synchroniser
    task automatic permit_set(input logic v);
        @(posedge aclk);
        permit <= v;
        repeat (8) @(posedge aclk);
    endtask
endmodule

// ==== verif/laser_gate_prot_tb.sv ====
/* Self-checking bench for the gate protection block.
   Assumes short counts set by parameters; sampling at falling edges. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module laser_gate_prot_tb;
    logic        aclk = 1'h0, aresetn, interlock_in, breakdown_in, fault_event_in;
    logic [11:0] fwd_level_in, refl_level_in;
    wire         beam_gate_in, run_permit_clear_in;
    logic        laser_out, simmer_out, pulse_overlimit_flag, reflection_guard_flag;
    logic        latched_error_out, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, ta, tw, tb;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rq;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    int          fail_count = 0, samples_checked = 0, w, n, i;
    laser_gate_prot #(.MAX_PULSE_CYC(20'h0_0040), .SIM_PERIOD_CYC(20'h0_012c),
        .SIM_TMO_CYC(20'h0_0032)) i_dut (.aclk, .aresetn, .beam_gate_in,
        .run_permit_clear_in, .interlock_in, .breakdown_in, .fault_event_in,
        .fwd_level_in, .refl_level_in, .laser_out, .simmer_out, .pulse_overlimit_flag,
        .reflection_guard_flag, .latched_error_out, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    laser_host_model i_host (.aclk, .gate(beam_gate_in), .permit(run_permit_clear_in));
    // 40 MHz clock
    initial begin
        forever #12.5 aclk = ~aclk;
    end
    task end_sim();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Settle k edges, then sample at the falling edge
    task nw(input int k);
        repeat (k) @(posedge aclk);
        @(negedge aclk);
    endtask
    // One AXI4-Lite access; readies sampled just before the edge that takes them
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        if (wr) begin
            {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'h3};
            s_axi_bready <= 1'h1;
        end else begin
            {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        end
        for (i = 0; i < 50; i++) begin
            @(negedge aclk);
            ta = s_axi_awready & s_axi_awvalid | s_axi_arready & s_axi_arvalid;
            tw = s_axi_wready & s_axi_wvalid;
            tb = s_axi_bvalid & s_axi_bready | s_axi_rvalid & s_axi_rready;
            {rq, rr} = {s_axi_rdata, wr ? s_axi_bresp : s_axi_rresp};
            @(posedge aclk);
            if (ta) {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
            if (tw) s_axi_wvalid <= 1'h0;
            if (tb) begin
                {s_axi_bready, s_axi_rready} <= 2'h0;
                break;
            end
        end
        if (i == 50) begin
            fail_count++;
            end_sim();
        end
    endtask
    // Width of the next simmer pulse, bounded waits
    task sw();
        for (n = 0; n < 2000 && simmer_out !== 1'h1; n++) @(negedge aclk);
        for (w = 0; w < 2000 && simmer_out === 1'h1; w++) @(negedge aclk);
        if (n == 2000 || w == 2000) begin
            fail_count++;
            end_sim();
        end
    endtask
    // Gate pulse with one check of {laser, a flag} k edges in
    task gp(input int hi, input int lo, input int k, input logic [1:0] e, input logic f);
        fork
            i_host.pulse(hi, lo);
            begin
                nw(k);
                `CHK("gate", e, {laser_out, f ? reflection_guard_flag : pulse_overlimit_flag})
            end
        join
    endtask
    initial begin
        {aresetn, fault_event_in, refl_level_in, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        {interlock_in, breakdown_in, s_axi_wstrb, s_axi_wdata} = {6'h3f, 32'h0000_0000};
        void'($urandom(32'h57f1_ec27));
        fwd_level_in = 12'h3e8 + 12'($urandom_range(40));
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        nw(0);
        `CHK("rst", 5'h00, {laser_out, simmer_out, pulse_overlimit_flag, reflection_guard_flag, latched_error_out})
        bus(0, laser_prot_pkg::CTRL_OFS, 0);
        `CHK("ctrl", 34'h0_0000_0004, {rq, rr})
        bus(0, laser_prot_pkg::RATIO_OFS, 0);
        `CHK("ratio", 34'h0_0000_00c8, {rq, rr})
        bus(0, 8'h10, 0);
        `CHK("unmapped", 34'h0_0000_0002, {rq, rr})
        $display("test regs done");
        gp(20, 10, 10, 2'h0, 0);
        i_host.permit_set(1'h1);
        gp(20, 10, 10, 2'h2, 0);
        gp(100, 10, 80, 2'h1, 0);
        gp(20, 10, 5, 2'h2, 0);
        fork
            begin repeat (2) i_host.pulse(50, 50); end
        join
        gp(50, 50, 48, 2'h1, 0);
        w = 10 + $urandom_range(20);
        repeat (2) i_host.pulse(w, 100 - w);
        gp(w, 100 - w, w - 4, 2'h2, 0);
        $display("test pulse done");
        @(posedge aclk);
        refl_level_in <= 12'h258;
        gp(30, 30, 15, 2'h1, 1);
        bus(1, laser_prot_pkg::RATIO_OFS, 32'h0000_0046);
        `CHK("bresp", laser_prot_pkg::RESP_OKAY, rr)
        gp(30, 30, 15, 2'h2, 1);
        refl_level_in <= 12'h000;
        fault_event_in <= 1'h1;
        @(posedge aclk);
        fault_event_in <= 1'h0;
        gp(20, 10, 10, 2'h0, 0);
        `CHK("fault", 1'h1, latched_error_out)
        i_host.permit_set(1'h0);
        i_host.permit_set(1'h1);
        nw(0);
        `CHK("clear", 1'h0, latched_error_out)
        $display("test fault done");
        i_host.pulse(10, 0);
        sw();
        `CHK("gap", 1'h1, n >= 298 && n <= 310)
        breakdown_in <= 1'h0;
        sw();
        sw();
        `CHK("lim", laser_prot_pkg::SIM_LIM_CYC, w)
        for (n = 0; n < 2000 && simmer_out !== 1'h1; n++) @(negedge aclk);
        fork
            i_host.pulse(20, 10);
            begin nw(5); `CHK("stop", 1'h0, simmer_out) end
        join
        @(posedge aclk);
        {interlock_in, breakdown_in} <= 2'h1;
        gp(20, 380, 10, 2'h0, 0);
        `CHK("ilk", 1'h0, simmer_out)
        interlock_in <= 1'h1;
        sw();
        `CHK("full", laser_prot_pkg::SIM_PW_CYC, w)
        bus(0, laser_prot_pkg::STAT_OFS, 0);
        `CHK("enabled", 1'h1, rq[laser_prot_pkg::ST_ENABLED])
        $display("test simmer done");
        end_sim();
    end
endmodule
